// file: design/disk_port_pkg.sv
// Shared constants and types for the disk controller host port
package disk_port_pkg;
  localparam int          DATA_W          = 8;
  localparam int          PTR_W           = 6;
  localparam int          DMA_CNT_W       = 16;
  localparam int          DRIVE_IN_W      = 6;
  // Drive input lane positions inside the synchroniser
  localparam int          IN_INDEX        = 0;
  localparam int          IN_SECTOR       = 1;
  localparam int          IN_SHARED2      = 2;
  localparam int          IN_SHARED1      = 3;
  localparam int          IN_AUX0         = 4;
  localparam int          IN_AUX1         = 5;
  // Register indices reached through the pointer
  localparam logic [5:0]  REG_AUX_STATUS  = 6'h04;
  localparam logic [5:0]  REG_CONTROL     = 6'h10;
  localparam logic [5:0]  REG_SECTOR_NUM  = 6'h11;
  // Bit positions
  localparam int          AUX0_BIT        = 6;
  localparam int          AUX1_BIT        = 7;
  localparam int          ST_SHARED2_BIT  = 2;
  localparam int          ST_SHARED1_BIT  = 1;
  localparam int          ST_STOPPED_BIT  = 0;
  localparam int          ST_REQ_BIT      = 3;
  localparam int          CTL_DMA_EN_BIT  = 0;
  localparam int          CTL_TO_RAM_BIT  = 1;
  localparam int          CTL_MODE_LSB    = 2;
  // Reset values
  localparam logic [5:0]  PTR_RESET       = 6'h00;
  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ   = 8'h00;
  localparam logic [7:0]  IDLE_BUS        = 8'hFF;

  typedef enum logic [1:0] {
    SECT_SOFT,
    SECT_HARD,
    SECT_ESDI_MARK,
    SECT_RSVD
  } sector_mode_t;
endpackage

// file: design/disk_port_if.sv
// Host port wires between the disk controller and the processor/DMA side
`timescale 1ns/1ns
interface disk_port_if;
  logic       host_select_n;
  logic       port_select_line;
  logic       write_not_read;
  logic [7:0] host_d_out;
  logic       host_d_oe;
  logic [7:0] dev_d_out;
  logic       dev_d_oe;
  logic [7:0] data;
  logic       dma_req_n;
  logic       dma_ack_n;
  logic       end_of_transfer_n;

  // Resolved level of the shared eight-line data bus
  assign data = dev_d_oe ? dev_d_out : (host_d_oe ? host_d_out : disk_port_pkg::IDLE_BUS);

  modport device (
    input  host_select_n, port_select_line, write_not_read, data, dma_ack_n, end_of_transfer_n,
    output dev_d_out, dev_d_oe, dma_req_n
  );
  modport host (
    input  data, dma_req_n,
    output host_select_n, port_select_line, write_not_read, host_d_out, host_d_oe, dma_ack_n,
           end_of_transfer_n
  );
endinterface

// file: design/drive_input_sync.sv
// Two-stage synchroniser for drive pins with rising edge detection
`timescale 1ns/1ns
module drive_input_sync (
  input  wire logic                                 clk,
  input  wire logic                                 reset,
  input  wire logic [disk_port_pkg::DRIVE_IN_W-1:0] pins,
  output logic      [disk_port_pkg::DRIVE_IN_W-1:0] level,
  output logic      [disk_port_pkg::DRIVE_IN_W-1:0] rise
);
  import disk_port_pkg::*;

  typedef struct packed {
    logic [DRIVE_IN_W-1:0] meta;
    logic [DRIVE_IN_W-1:0] sync;
    logic [DRIVE_IN_W-1:0] prev;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  always_comb begin
    state_next      = state_reg;
    state_next.meta = pins;
    state_next.sync = state_reg.meta;
    state_next.prev = state_reg.sync;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Edges are taken between the second and third stage, never from the first
  assign level = state_reg.sync;
  assign rise  = state_reg.sync & ~state_reg.prev;
endmodule

// file: design/disk_port_device.sv
// Disk controller end: host register port, DMA byte handshake and drive status inputs
`timescale 1ns/1ns
// Function
// - End-of-transfer counts only with acknowledge low
// - Port select low: pointer write, status read
// - Port select high: register chosen by pointer
// - Processor: write-not-read low writes, high reads
// - Direction line ignored while select high
// - Processor asserts select for every access
// - Everything timed by buffer clock rising edges
// - Aux input 0 read at register 04 bit 6
// - Aux input 1 read at register 04 bit 7
// - Index rising edge starts the track
// - Hard sectored: sector edges start later sectors
// - ESDI marks start later sectors; index sector 0
// - Stepper: positioning-done shown as status bit 2
// - ESDI: serial status shown as status bit 2
// - Tape: lower hole shown as status bit 2
// - Stepper: cylinder zero shown as status bit 1
// - ESDI: handshake reply shown as status bit 1
// - Tape: upper hole shown as status bit 1
// - End-of-transfer: finish sector, no requests, pad
// - During acknowledge drive or accept one byte
// - DMA side holds acknowledge one full cycle
// - Data lines change on buffer clock rise
module disk_port_device (
  input  wire logic                                 clk,
  input  wire logic                                 reset,
  disk_port_if.device                               port,
  input  wire logic [disk_port_pkg::DRIVE_IN_W-1:0] drive_pins,
  input  wire logic [disk_port_pkg::DATA_W-1:0]     disk_rd_byte,
  input  wire logic                                 disk_rd_valid,
  input  wire logic                                 disk_wr_need,
  input  wire logic                                 sector_done,
  output logic      [disk_port_pkg::DATA_W-1:0]     disk_wr_byte,
  output logic                                      disk_wr_fresh,
  output logic                                      track_start,
  output logic                                      sector_start,
  output logic      [disk_port_pkg::DATA_W-1:0]     sector_number,
  output logic                                      transfer_stopped
);
  import disk_port_pkg::*;

  // Whole device state in one record: the next-state block fills a copy, one flop stage holds it
  typedef struct packed {
    logic [PTR_W-1:0]  ptr;
    logic [DATA_W-1:0] control;
    logic [DATA_W-1:0] sector_num;
    logic [DATA_W-1:0] rd_data;
    logic              rd_oe;
    logic              req;
    logic              stopped;
    logic [DATA_W-1:0] ram_byte;
    logic [DATA_W-1:0] last_byte;
    logic              wr_fresh;
    logic              track_start;
    logic              sector_start;
  } dev_state_t;

  dev_state_t              state_reg;
  dev_state_t              state_next;
  logic [DRIVE_IN_W-1:0]   in_level;
  logic [DRIVE_IN_W-1:0]   in_rise;
  logic                    selected;
  logic                    host_wr;
  logic                    host_rd;
  logic                    ack;
  logic                    to_ram;
  logic                    dma_en;
  sector_mode_t            mode;
  logic [DATA_W-1:0]       status_byte;

  drive_input_sync u_sync (
    .clk   (clk),
    .reset (reset),
    .pins  (drive_pins),
    .level (in_level),
    .rise  (in_rise)
  );

  // Data port read side; the pointer never advances by itself, so block reads rewrite it
  function automatic logic [DATA_W-1:0] read_mux(input logic [PTR_W-1:0] idx, input dev_state_t s,
                                                 input logic [DRIVE_IN_W-1:0] lv);
    logic [DATA_W-1:0] v;
    v = UNMAPPED_READ;
    unique case (idx)
      REG_AUX_STATUS: begin
        v[AUX0_BIT] = lv[IN_AUX0];
        v[AUX1_BIT] = lv[IN_AUX1];
      end
      REG_CONTROL:    v = s.control;
      REG_SECTOR_NUM: v = s.sector_num;
      default:        v = UNMAPPED_READ;
    endcase
    return v;
  endfunction

  assign selected = !port.host_select_n;
  // Direction line only has meaning while the chip is selected
  assign host_wr  = selected && !port.write_not_read;
  assign host_rd  = selected && port.write_not_read;
  assign ack      = !port.dma_ack_n;
  assign dma_en   = state_reg.control[CTL_DMA_EN_BIT];
  assign to_ram   = state_reg.control[CTL_TO_RAM_BIT];
  assign mode     = sector_mode_t'(state_reg.control[CTL_MODE_LSB +: 2]);

  // The two shared inputs land on the same bits whatever drive or tape is fitted;
  // software knows which meaning applies from the drive type it set up
  always_comb begin
    status_byte                 = '0;
    status_byte[ST_SHARED2_BIT] = in_level[IN_SHARED2];
    status_byte[ST_SHARED1_BIT] = in_level[IN_SHARED1];
    status_byte[ST_STOPPED_BIT] = state_reg.stopped;
    status_byte[ST_REQ_BIT]     = state_reg.req;
  end

  always_comb begin
    state_next              = state_reg;
    state_next.rd_oe        = 1'b0;
    state_next.track_start  = 1'b0;
    state_next.sector_start = 1'b0;
    state_next.wr_fresh     = 1'b0;

    // Register port
    // Data port writes land only while the pointer names the control register
    if (host_wr) begin
      if (!port.port_select_line) begin
        state_next.ptr = port.data[PTR_W-1:0];
      end else if (state_reg.ptr == REG_CONTROL) begin
        state_next.control = port.data;
      end
    end

    // The answer stands on the bus for exactly one cycle after the read strobe
    if (host_rd) begin
      state_next.rd_oe   = 1'b1;
      state_next.rd_data = port.port_select_line ? read_mux(state_reg.ptr, state_reg, in_level)
                                                 : status_byte;
    end

    // Track and sector starts; the index edge also opens sector 0
    // Soft sectoring ignores the sector input; the number wraps after 255 unchecked
    if (in_rise[IN_INDEX]) begin
      state_next.sector_num   = '0;
      state_next.track_start  = 1'b1;
      state_next.sector_start = 1'b1;
    end else if (in_rise[IN_SECTOR] && (mode == SECT_HARD || mode == SECT_ESDI_MARK)) begin
      state_next.sector_num   = state_reg.sector_num + 8'h01;
      state_next.sector_start = 1'b1;
    end

    // DMA request side; a stopped transfer raises no new request
    // Only one byte is ever in flight, so no buffer sits between disk and RAM
    if (dma_en && !state_reg.req && !state_reg.stopped) begin
      if (to_ram && disk_rd_valid) begin
        state_next.ram_byte = disk_rd_byte;
        state_next.req      = 1'b1;
      end else if (!to_ram && disk_wr_need) begin
        state_next.req = 1'b1;
      end
    end

    // End-of-transfer is only looked at inside an acknowledged cycle
    if (ack && state_reg.req) begin
      state_next.req = 1'b0;
      if (!to_ram) begin
        state_next.last_byte = port.data;
        state_next.wr_fresh  = 1'b1;
      end
      if (!port.end_of_transfer_n) begin
        state_next.stopped = 1'b1;
      end
    end
    // The stop holds until the disk side reports the sector finished
    if (sector_done && state_reg.stopped && !(ack && !port.end_of_transfer_n)) begin
      state_next.stopped = 1'b0;
    end
    if (!dma_en) begin
      state_next.req = 1'b0;
    end
  end

  // Pointer and control take their named reset values; everything else clears
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg         <= '0;
      state_reg.ptr     <= PTR_RESET;
      state_reg.control <= CONTROL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Enable follows acknowledge; the byte itself comes from a flip-flop
  // A host write in the very cycle of a read answer loses the bus to that answer
  assign port.dev_d_oe  = state_reg.rd_oe || (ack && state_reg.req && to_ram);
  assign port.dev_d_out = state_reg.rd_oe ? state_reg.rd_data : state_reg.ram_byte;
  assign port.dma_req_n = !state_reg.req;
  // After a stop the last byte keeps feeding the writer, padding the sector
  assign disk_wr_byte     = state_reg.last_byte;
  assign disk_wr_fresh    = state_reg.wr_fresh;
  assign track_start      = state_reg.track_start;
  assign sector_start     = state_reg.sector_start;
  assign sector_number    = state_reg.sector_num;
  assign transfer_stopped = state_reg.stopped;
endmodule

// file: design/disk_port_host.sv
// Processor and DMA end of the disk controller host port
`timescale 1ns/1ns
module disk_port_host (
  input  wire logic                                clk,
  input  wire logic                                reset,
  disk_port_if.host                                port,
  input  wire logic                                addr,
  input  wire logic [disk_port_pkg::DATA_W-1:0]    wdata,
  input  wire logic                                wr,
  input  wire logic                                rd,
  output logic      [disk_port_pkg::DATA_W-1:0]    rdata,
  input  wire logic                                dma_go,
  input  wire logic [disk_port_pkg::DMA_CNT_W-1:0] dma_len,
  input  wire logic                                dma_to_disk,
  input  wire logic [disk_port_pkg::DATA_W-1:0]    dma_wdata,
  output logic                                     dma_wtake,
  output logic      [disk_port_pkg::DATA_W-1:0]    dma_rdata,
  output logic                                     dma_rvalid,
  output logic                                     dma_busy
);
  import disk_port_pkg::*;

  typedef struct packed {
    logic                 rd_pending;
    logic                 ack_prev;
    logic [DMA_CNT_W-1:0] count;
    logic                 to_disk;
    logic [DATA_W-1:0]    rbyte;
    logic                 rvalid;
  } host_state_t;

  host_state_t state_reg;
  host_state_t state_next;
  logic        ack;
  logic        access;

  assign access = wr || rd;
  // Register access owns the bus, including the cycle the device answers a read
  assign ack = (state_reg.count != '0) && !port.dma_req_n && !access && !state_reg.rd_pending
               && !state_reg.ack_prev;

  always_comb begin
    state_next            = state_reg;
    state_next.rd_pending = rd;
    state_next.ack_prev   = ack;
    state_next.rvalid     = 1'b0;
    if (dma_go && state_reg.count == '0) begin
      state_next.count   = dma_len;
      state_next.to_disk = dma_to_disk;
    end
    if (ack) begin
      state_next.count = state_reg.count - 16'h0001;
      if (!state_reg.to_disk) begin
        state_next.rbyte  = port.data;
        state_next.rvalid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign port.host_select_n     = !access;
  assign port.port_select_line  = addr;
  assign port.write_not_read    = !wr;
  assign port.host_d_oe         = wr || (ack && state_reg.to_disk);
  assign port.host_d_out        = wr ? wdata : dma_wdata;
  assign port.dma_ack_n         = !ack;
  assign port.end_of_transfer_n = !(ack && state_reg.count == 16'h0001);
  assign rdata      = state_reg.rd_pending ? port.data : '0;
  assign dma_wtake  = ack && state_reg.to_disk;
  assign dma_rdata  = state_reg.rbyte;
  assign dma_rvalid = state_reg.rvalid;
  assign dma_busy   = state_reg.count != '0;
endmodule

// file: bench/disk_port_monitor.sv
// Protocol checker watching the wires between the two host port ends
`timescale 1ns/1ns
module disk_port_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic host_select_n,
  input wire logic port_select_line,
  input wire logic write_not_read,
  input wire logic host_d_oe,
  input wire logic dev_d_oe,
  input wire logic dma_req_n,
  input wire logic dma_ack_n,
  input wire logic end_of_transfer_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_rd_ptr; !host_select_n && write_not_read && !port_select_line; endsequence
  sequence s_rd_reg; !host_select_n && write_not_read && port_select_line; endsequence
  sequence s_answer; dev_d_oe; endsequence
  sequence s_stop_ack; !dma_ack_n && !end_of_transfer_n; endsequence

  property p_status_read; s_rd_ptr |=> s_answer; endproperty
  a_status_read: assert property (p_status_read) else $error("status read not answered");
  property p_reg_read; s_rd_reg |=> s_answer; endproperty
  a_reg_read: assert property (p_reg_read) else $error("register read not answered");
  // Device may only drive after a selected read or during acknowledge
  property p_drive_cause; dev_d_oe |-> $past(!host_select_n && write_not_read) || !dma_ack_n; endproperty
  a_drive_cause: assert property (p_drive_cause) else $error("device drove bus without cause");
  property p_write_drives; !host_select_n && !write_not_read |-> host_d_oe; endproperty
  a_write_drives: assert property (p_write_drives) else $error("write without host data");
  property p_host_drive; host_d_oe |-> (!host_select_n && !write_not_read) || !dma_ack_n; endproperty
  a_host_drive: assert property (p_host_drive) else $error("host drove bus outside a cycle");
  property p_ack_width; $fell(dma_ack_n) |=> dma_ack_n; endproperty
  a_ack_width: assert property (p_ack_width) else $error("acknowledge longer than one cycle");
  property p_eot_with_ack; !end_of_transfer_n |-> !dma_ack_n; endproperty
  a_eot_with_ack: assert property (p_eot_with_ack) else $error("end of transfer without ack");
  property p_stop_release; s_stop_ack |=> dma_req_n; endproperty
  a_stop_release: assert property (p_stop_release) else $error("request after final ack");
  property p_ack_byte; !dma_ack_n |-> !dma_req_n && (dev_d_oe || host_d_oe); endproperty
  a_ack_byte: assert property (p_ack_byte) else $error("ack without request or byte");
endmodule

// file: bench/disk_ctrl_host_port_status_test.sv
// Self-checking bench joining both ends of the disk controller host port
`timescale 1ns/1ns
module disk_ctrl_host_port_status_test;
  import disk_port_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [5:0]  drive_pins = 6'h00;
  logic [7:0]  disk_rd_byte = 8'h00;
  logic        disk_rd_valid = 1'b0, disk_wr_need = 1'b0, sector_done = 1'b0;
  logic        addr = 1'b0, wr = 1'b0, rd = 1'b0, dma_go = 1'b0, dma_to_disk = 1'b0;
  logic [7:0]  wdata = 8'h00, dma_wdata = 8'h00;
  logic [15:0] dma_len = 16'h0000;
  logic [7:0]  disk_wr_byte, sector_number, rdata, dma_rdata;
  logic        disk_wr_fresh, track_start, sector_start, transfer_stopped, dma_wtake, dma_rvalid, dma_busy;
  int          bad_count = 0, checked = 0, trk_cnt = 0, sec_cnt = 0, take_cnt = 0;

  disk_port_if bus ();
  disk_port_device disk_port_device_i (.clk(clk), .reset(reset), .port(bus.device), .drive_pins(drive_pins),
    .disk_rd_byte(disk_rd_byte), .disk_rd_valid(disk_rd_valid), .disk_wr_need(disk_wr_need),
    .sector_done(sector_done), .disk_wr_byte(disk_wr_byte), .disk_wr_fresh(disk_wr_fresh),
    .track_start(track_start), .sector_start(sector_start), .sector_number(sector_number),
    .transfer_stopped(transfer_stopped));
  disk_port_host disk_port_host_i (.clk(clk), .reset(reset), .port(bus.host), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .dma_go(dma_go), .dma_len(dma_len), .dma_to_disk(dma_to_disk),
    .dma_wdata(dma_wdata), .dma_wtake(dma_wtake), .dma_rdata(dma_rdata), .dma_rvalid(dma_rvalid),
    .dma_busy(dma_busy));
  disk_port_monitor disk_port_monitor_i (.clk(clk), .reset(reset), .host_select_n(bus.host_select_n),
    .port_select_line(bus.port_select_line), .write_not_read(bus.write_not_read), .host_d_oe(bus.host_d_oe),
    .dev_d_oe(bus.dev_d_oe), .dma_req_n(bus.dma_req_n), .dma_ack_n(bus.dma_ack_n),
    .end_of_transfer_n(bus.end_of_transfer_n));

  // Counted on the falling edge so the pulse registers have settled
  always @(negedge clk) begin
    if (track_start === 1'b1) trk_cnt++;
    if (sector_start === 1'b1) sec_cnt++;
    if (dma_wtake === 1'b1) take_cnt++;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic reg_wr(input logic a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #50 d = rdata;
  endtask
  task automatic reg_at(input logic [5:0] p, output logic [7:0] d);
    reg_wr(1'b0, {2'b00, p});
    reg_rd(1'b1, d);
  endtask
  task automatic set_ctl(input logic [7:0] v);
    reg_wr(1'b0, {2'b00, REG_CONTROL});
    reg_wr(1'b1, v);
  endtask
  task automatic strobe(input int sel);
    @(posedge clk);
    disk_rd_valid <= (sel == 0);
    disk_wr_need <= (sel == 1);
    sector_done <= (sel == 2);
    @(posedge clk);
    {disk_rd_valid, disk_wr_need, sector_done} <= 3'b000;
  endtask
  task automatic pin_pulse(input int lane);
    @(posedge clk);
    drive_pins[lane] <= 1'b1;
    cyc(5);
    drive_pins[lane] <= 1'b0;
    cyc(5);
  endtask
  task automatic dma_start(input logic [15:0] len, input logic to_disk);
    @(posedge clk);
    dma_go <= 1'b1;
    dma_len <= len;
    dma_to_disk <= to_disk;
    @(posedge clk);
    dma_go <= 1'b0;
  endtask

  task automatic t_status();
    logic [7:0] s;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      drive_pins[IN_SHARED2] <= k[0];
      drive_pins[IN_SHARED1] <= k[1];
      cyc(4);
      reg_rd(1'b0, s);
      chk("status bit2", {7'h00, k[0]}, {7'h00, s[ST_SHARED2_BIT]});
      chk("status bit1", {7'h00, k[1]}, {7'h00, s[ST_SHARED1_BIT]});
      chk("status idle bits", 8'h00, s & 8'h09);
    end
  endtask
  task automatic t_aux();
    logic [7:0] s;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      drive_pins[IN_AUX0] <= k[0];
      drive_pins[IN_AUX1] <= k[1];
      cyc(4);
      reg_at(REG_AUX_STATUS, s);
      chk("aux0", {7'h00, k[0]}, {7'h00, s[AUX0_BIT]});
      chk("aux1", {7'h00, k[1]}, {7'h00, s[AUX1_BIT]});
    end
    reg_at(6'h3F, s);
    chk("unmapped read", UNMAPPED_READ, s);
  endtask
  task automatic t_sector();
    logic [7:0] s;
    logic [7:0] exp;
    for (int m = 0; m < 3; m++) begin
      set_ctl({4'h0, 2'(m), 2'b00});
      reg_at(REG_CONTROL, s);
      chk("control readback", {4'h0, 2'(m), 2'b00}, s);
      trk_cnt = 0;
      sec_cnt = 0;
      pin_pulse(IN_INDEX);
      chk("sector after index", 8'h00, sector_number);
      pin_pulse(IN_SECTOR);
      pin_pulse(IN_SECTOR);
      // Soft sectoring must ignore the sector pin altogether
      exp = (m == 0) ? 8'h00 : 8'h02;
      chk("track starts", 8'h01, 8'(trk_cnt));
      chk("sector starts", exp + 8'h01, 8'(sec_cnt));
      reg_at(REG_SECTOR_NUM, s);
      chk("sector number", exp, s);
    end
  endtask
  task automatic t_dma_rd();
    logic [7:0] s;
    logic [7:0] b;
    int         n;
    set_ctl(8'h03);
    dma_start(16'h0002, 1'b0);
    for (int i = 0; i < 2; i++) begin
      b = (i == 0) ? 8'hA5 : 8'h3C;
      @(posedge clk);
      disk_rd_byte <= b;
      strobe(0);
      for (int w = 0; w < 20 && dma_rvalid !== 1'b1; w++) @(negedge clk);
      chk("dma byte to ram", b, dma_rdata);
    end
    cyc(2);
    reg_rd(1'b0, s);
    chk("stopped after final", 8'h01, {7'h00, s[ST_STOPPED_BIT]});
    chk("stop output", 8'h01, {7'h00, transfer_stopped});
    chk("busy after final", 8'h00, {7'h00, dma_busy});
    strobe(0);
    n = 0;
    repeat (6) @(negedge clk) if (bus.dma_req_n !== 1'b1) n++;
    chk("requests after stop", 8'h00, 8'(n));
    strobe(2);
    cyc(2);
    reg_rd(1'b0, s);
    chk("stop cleared", 8'h00, {7'h00, s[ST_STOPPED_BIT]});
  endtask
  task automatic t_dma_wr();
    logic [7:0] s;
    set_ctl(8'h00);
    set_ctl(8'h01);
    dma_wdata <= 8'h5A;
    dma_start(16'h0001, 1'b1);
    strobe(1);
    for (int w = 0; w < 20 && disk_wr_fresh !== 1'b1; w++) @(negedge clk);
    chk("byte from ram", 8'h5A, disk_wr_byte);
    @(posedge clk);
    dma_wdata <= 8'hC3;
    strobe(1);
    cyc(4);
    chk("pad byte", 8'h5A, disk_wr_byte);
    chk("ram bytes taken", 8'h01, 8'(take_cnt));
    reg_rd(1'b0, s);
    chk("stopped after write", 8'h01, {7'h00, s[ST_STOPPED_BIT]});
    strobe(2);
  endtask

  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    cyc(16);
    reset <= 1'b0;
    t_status();
    t_aux();
    t_sector();
    t_dma_rd();
    t_dma_wr();
    conclude();
  end
  // Whole run needs some three hundred cycles; twenty thousand means a hang
  initial begin
    #2000000;
    bad_count++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    conclude();
  end
endmodule
